// ===== bench/dmb_base_reg_properties.sv
// Checker for the window 3 base address register ports
`timescale 1ns/1ps
module dmb_base_reg_properties
  import dmb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched ports
  input wire dmb_cfg_req_s cfg_req,
  input wire dmb_cfg_rsp_s cfg_rsp,
  input wire dmb_txn_s txn,
  input wire dmb_fwd_s fwd,
  input wire logic window_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_ACK_ONE_CYCLE: assert property (cfg_rsp.ack == $past(cfg_req.req))
    else $error("ack not one cycle after request");
  AST_CLAIM_OFFSET: assert property (cfg_req.req |=> cfg_rsp.claim ==
    ($past(cfg_req.off) == DMB_CFG_OFF_BASE)) else $error("claim wrong for offset");
  AST_SPACE_MEM: assert property (cfg_rsp.claim |-> cfg_rsp.rdata[0] == DMB_SPACE_MEM)
    else $error("space indicator not memory");
  AST_TYPE_LEGAL: assert property (cfg_rsp.claim |-> !cfg_rsp.rdata[2] &&
    cfg_rsp.rdata[11:4] == 8'h00) else $error("reserved type or low bits set");
  AST_UNCLAIMED_ZERO: assert property (cfg_rsp.ack && !cfg_rsp.claim |->
    cfg_rsp.rdata == DMB_DW_ZERO) else $error("unclaimed read not zero");
  AST_FWD_LATENCY: assert property (fwd.valid == $past(txn.valid))
    else $error("forward result not one cycle after transaction");
  AST_MISS_PASS: assert property (fwd.valid && !fwd.hit |-> fwd.addr == $past(txn.addr))
    else $error("missed address altered");
  AST_NOXLAT_PASS: assert property (fwd.hit && !fwd.xlat |-> fwd.addr == $past(txn.addr))
    else $error("untranslated hit altered address");
  AST_XLAT_LOW: assert property (fwd.xlat |-> fwd.hit && fwd.addr[63:32] == 32'h0)
    else $error("translated address not 32-bit");
  cover property (cfg_rsp.claim && window_en);
  cover property (fwd.xlat);
  cover property (fwd.hit && !fwd.xlat);
endmodule

bind dmb_base_reg dmb_base_reg_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .txn(txn), .fwd(fwd), .window_en(window_en));

// ===== bench/dmb_base_reg_tb.sv
// Testbench for the window 3 base address register
`timescale 1ns/1ps
module dmb_base_reg_tb;
  import dmb_pkg::*;
  logic ref_clk, rst_n, window_en;
  logic [31:0] upper_base;
  dmb_cfg_req_s cfg_req;
  dmb_cfg_rsp_s cfg_rsp, rsp;
  dmb_cs_wr_s eeprom_wr, smbus_wr, lproc_wr;
  dmb_txn_s txn;
  dmb_fwd_s fwd, fr;
  int n_fail, num_checks, cycles;
  dmb_base_reg DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .eeprom_wr(eeprom_wr), .smbus_wr(smbus_wr), .lproc_wr(lproc_wr),
    .upper_base(upper_base), .txn(txn), .fwd(fwd), .window_en(window_en));
  dmb_host_model HOST (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .txn(txn), .fwd(fwd));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic acc(input logic we, input logic [3:0] be, input logic [31:0] wd, exp);
    HOST.cfg(we, DMB_CFG_OFF_BASE, be, wd, rsp);
    chk(rsp, {2'b11, exp});
  endtask
  task automatic dq(input logic [63:0] a, input logic [2:0] f, input logic [63:0] ea);
    HOST.dec(a, fr);
    chk(fr.addr, ea);
    chk({fr.valid, fr.hit, fr.xlat}, f);
  endtask
  // Preload from source 0 eeprom, 1 smbus, 2 local processor
  task automatic pre(input int src, input logic [11:0] off, input logic [31:0] wd);
    @(negedge ref_clk);
    if (src == 0) eeprom_wr = '{1'b1, off, wd};
    else if (src == 1) smbus_wr = '{1'b1, off, wd};
    else lproc_wr = '{1'b1, off, wd};
    @(negedge ref_clk);
    eeprom_wr = '0;
    smbus_wr = '0;
    lproc_wr = '0;
    @(negedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    upper_base = 32'h0;
    eeprom_wr = '0;
    smbus_wr = '0;
    lproc_wr = '0;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    acc(1'b0, 4'hF, 32'h0, 32'h0);
    chk(window_en, 1'b0);
    acc(1'b1, 4'hF, 32'hFFFFFFFF, 32'h0);
    acc(1'b0, 4'hF, 32'h0, 32'h0);
    $display("test reset and locked done");
    pre(0, DMB_CS_OFF_SETUP, 32'hFFFF0000);
    acc(1'b1, 4'hF, 32'hFFFFFFFF, 32'h0);
    acc(1'b0, 4'hF, 32'h0, 32'hFFFF0000);
    acc(1'b1, 4'hC, 32'h12340000, 32'h0);
    acc(1'b0, 4'hF, 32'h0, 32'h12340000);
    chk(window_en, 1'b1);
    pre(1, DMB_CS_OFF_XLAT, 32'hABCD0000);
    dq(64'h12345678, 3'b111, 64'hABCD5678);
    dq(64'h112345678, 3'b100, 64'h112345678);
    pre(2, DMB_CS_OFF_SETUP, 32'h7FFF0000);
    chk(window_en, 1'b0);
    dq(64'h12345678, 3'b100, 64'h12345678);
    $display("test 32-bit window done");
    pre(0, DMB_CS_OFF_SETUP, 32'hFFFF000A);
    pre(1, DMB_CS_OFF_USETUP, 32'h80000000);
    acc(1'b0, 4'hF, 32'h0, 32'h1234000A);
    chk(window_en, 1'b1);
    dq(64'h12349ABC, 3'b110, 64'h12349ABC);
    dq(64'h8000000012349ABC, 3'b100, 64'h8000000012349ABC);
    pre(2, DMB_CS_OFF_USETUP, 32'h0);
    chk(window_en, 1'b0);
    dq(64'h12349ABC, 3'b100, 64'h12349ABC);
    $display("test 64-bit window done");
    pre(2, DMB_CS_OFF_USETUP, 32'h80000000);
    acc(1'b1, 4'hF, 32'h0, 32'h0);
    acc(1'b0, 4'hF, 32'h0, 32'h0000000A);
    chk(window_en, 1'b0);
    dq(64'h0, 3'b100, 64'h0);
    HOST.cfg(1'b0, 8'h24, 4'hF, 32'h0, rsp);
    chk(rsp, {2'b10, 32'h0});
    $display("test zero base and unmapped done");
    conclude();
  end
endmodule

// ===== bench/dmb_host_model.sv
// Host model issuing configuration accesses and transactions
`timescale 1ns/1ps
module dmb_host_model
  import dmb_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Configuration side
  output dmb_cfg_req_s cfg_req,
  input wire dmb_cfg_rsp_s cfg_rsp,
  // Transaction side
  output dmb_txn_s txn,
  input wire dmb_fwd_s fwd
);
  initial begin
    cfg_req = '0;
    txn = '0;
  end
  // Pulse one access, take the answer, leave inverted leftovers
  task automatic cfg(input logic we, input logic [7:0] off, input logic [3:0] be,
      input logic [31:0] wd, output dmb_cfg_rsp_s rsp);
    @(negedge ref_clk);
    cfg_req = '{1'b1, we, off, be, wd};
    @(negedge ref_clk);
    rsp = cfg_rsp;
    cfg_req = '{1'b0, ~we, ~off, ~be, ~wd};
  endtask
  task automatic dec(input logic [63:0] a, output dmb_fwd_s f);
    @(negedge ref_clk);
    txn = '{1'b1, a};
    @(negedge ref_clk);
    f = fwd;
    txn = '{1'b0, ~a};
  endtask
endmodule

// ===== hdl/dmb_base_reg.sv
// Downstream memory window 3 base address register with decode and translation
// Function
// - The space indicator reads 0, a memory window, from reset onward.
// - The address type is read-only, 00 for 32-bit and 01 for 64-bit decode, reset 00.
// - The prefetch indicator is read-only, 1 for prefetchable, reset 0.
// - Window size and type come from the setup register at control-space offset 014h.
// - The setup register may be preloaded by an EEPROM, an SMBus master or a local processor.
// - A zero in bit 31 of the setup register at 014h, or in 64-bit mode of the one at 018h, disables this window.
// - In 32-bit mode window sizes from 4KB up to 2GB are supported, as enable bit 31 of the setup register at 014h is also a mask bit.
// - In 32-bit mode hits are translated with the translated base at offset 010h.
// - In 64-bit mode hits are forwarded with no translation.
// - A base bit is writable only where the matching setup bit is one.
// - The base field resets to zero and while zero the window claims nothing.
`timescale 1ns/1ps
module dmb_base_reg
  import dmb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host configuration access
  input wire dmb_cfg_req_s cfg_req,
  output dmb_cfg_rsp_s cfg_rsp,
  // Setup preload sources, highest priority first
  input wire dmb_cs_wr_s eeprom_wr,
  input wire dmb_cs_wr_s smbus_wr,
  input wire dmb_cs_wr_s lproc_wr,
  // Upper 32 bits of the window base, held outside this block
  input wire logic [31:0] upper_base,
  // Transactions to decode and their forwarding result
  input wire dmb_txn_s txn,
  output dmb_fwd_s fwd,
  // Window state
  output logic window_en
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] dmb_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [DMB_BASE_W-1:0] dmb_wmask(input logic [31:0] setup);
    return setup[31:DMB_BASE_LO];
  endfunction

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic dmb_is_base(input dmb_cfg_req_s r);
    return r.req && (r.off == DMB_CFG_OFF_BASE);
  endfunction

  function automatic logic dmb_is_64(input logic [1:0] t);
    return t == DMB_TYPE_64;
  endfunction

  // Bits outside the mask keep their old value
  function automatic logic [DMB_BASE_W-1:0] dmb_merge(input logic [DMB_BASE_W-1:0] old,
      input logic [DMB_BASE_W-1:0] data, input logic [DMB_BASE_W-1:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction

  function automatic logic dmb_hit(input logic [63:0] addr, input logic [63:0] mask,
      input logic [63:0] base);
    return (addr & mask) == (base & mask);
  endfunction

  // Only the low 32 bits are rebased, so the result is always a 32-bit address
  function automatic logic [63:0] dmb_xlat_addr(input logic [31:0] xbase,
      input logic [31:0] addr, input logic [31:0] mask);
    return {32'h00000000, (xbase & mask) | (addr & ~mask)};
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dmb_state_s st_r;
  dmb_state_s st_nxt;
  dmb_cs_wr_s cs_sel;
  logic [DMB_BASE_W-1:0] wmask;
  logic [1:0] addr_type;
  logic en_w;
  logic [63:0] full_mask;
  logic [63:0] full_base;
  logic [31:0] bar_rd;
  logic [31:0] wr_mask;

  // ---------------------------------------------------------------
  // Preload source select
  // ---------------------------------------------------------------
  always_comb begin
    if (eeprom_wr.req) begin
      cs_sel = eeprom_wr;
    end else if (smbus_wr.req) begin
      cs_sel = smbus_wr;
    end else begin
      cs_sel = lproc_wr;
    end
  end

  // ---------------------------------------------------------------
  // Derived window attributes
  // ---------------------------------------------------------------
  always_comb begin
    wmask = dmb_wmask(st_r.setup);
    // type from setup, reserved codes fall back to 32-bit
    addr_type = dmb_is_64(st_r.setup[DMB_TYPE_LO +: 2]) ? DMB_TYPE_64 : DMB_TYPE_32;
    en_w = st_r.setup[DMB_ENABLE_BIT] &&
           (!dmb_is_64(addr_type) || st_r.usetup[DMB_ENABLE_BIT]) &&
           (st_r.base != DMB_BASE_RST);
    // 64-bit mask spans 4KB to 8EB
    full_mask = {dmb_is_64(addr_type) ? st_r.usetup : 32'hFFFFFFFF,
                 wmask, 12'h000};
    full_base = {dmb_is_64(addr_type) ? upper_base : 32'h00000000,
                 st_r.base, 12'h000};
    // memory space; prefetch; read-only bits zero
    bar_rd = {st_r.base & wmask, 8'h00, st_r.setup[DMB_PREF_BIT], addr_type, DMB_SPACE_MEM};
    wr_mask = dmb_be_mask(cfg_req.be);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Control-space preload writes
    if (cs_sel.req) begin
      unique case (cs_sel.off)
        DMB_CS_OFF_SETUP: begin
          st_nxt.setup = cs_sel.wdata;
        end
        DMB_CS_OFF_USETUP: begin
          st_nxt.usetup = cs_sel.wdata;
        end
        DMB_CS_OFF_XLAT: begin
          st_nxt.xlat = cs_sel.wdata;
        end
        default: begin
          st_nxt.xlat = st_r.xlat;
        end
      endcase
    end
    // Host configuration access, answered one cycle later
    st_nxt.cfg.ack = cfg_req.req;
    st_nxt.cfg.claim = dmb_is_base(cfg_req);
    st_nxt.cfg.rdata = DMB_DW_ZERO;
    if (dmb_is_base(cfg_req)) begin
      if (cfg_req.we) begin
        // writable only where setup bit set
        st_nxt.base = dmb_merge(st_r.base, cfg_req.wdata[31:DMB_BASE_LO],
                                wmask & wr_mask[31:DMB_BASE_LO]);
      end else begin
        st_nxt.cfg.rdata = bar_rd;
      end
    end
    // Transaction decode and forwarding
    st_nxt.fwd.valid = txn.valid;
    st_nxt.fwd.hit = 1'b0;
    st_nxt.fwd.xlat = 1'b0;
    st_nxt.fwd.addr = txn.addr;
    if (txn.valid && en_w && dmb_hit(txn.addr, full_mask, full_base)) begin
      st_nxt.fwd.hit = 1'b1;
      if (!dmb_is_64(addr_type)) begin
        st_nxt.fwd.xlat = 1'b1;
        st_nxt.fwd.addr = dmb_xlat_addr(st_r.xlat, txn.addr[31:0], full_mask[31:0]);
      end else begin
        st_nxt.fwd.addr = txn.addr;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r.base <= DMB_BASE_RST;
      st_r.setup <= DMB_SETUP_RST;
      st_r.usetup <= DMB_SETUP_RST;
      st_r.xlat <= DMB_XLAT_RST;
      st_r.cfg <= '0;
      st_r.fwd <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Window enable register
  // ---------------------------------------------------------------
  logic window_en_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      window_en_r <= 1'b0;
    end else begin
      window_en_r <= en_w;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cfg_rsp = st_r.cfg;
  assign fwd = st_r.fwd;
  assign window_en = window_en_r;

endmodule

// ===== hdl/dmb_pkg.sv
// Package: constants and carriers for the downstream memory 3 base address register
package dmb_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] DMB_CFG_OFF_BASE = 8'h20;
  localparam logic [11:0] DMB_CS_OFF_XLAT = 12'h010;
  localparam logic [11:0] DMB_CS_OFF_SETUP = 12'h014;
  localparam logic [11:0] DMB_CS_OFF_USETUP = 12'h018;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DMB_SPACE_BIT = 0;
  localparam int DMB_TYPE_LO = 1;
  localparam int DMB_PREF_BIT = 3;
  localparam int DMB_BASE_LO = 12;
  localparam int DMB_ENABLE_BIT = 31;
  localparam int DMB_BASE_W = 20;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic DMB_SPACE_MEM = 1'b0;
  localparam logic [1:0] DMB_TYPE_32 = 2'h0;
  localparam logic [1:0] DMB_TYPE_64 = 2'h1;
  localparam logic [DMB_BASE_W-1:0] DMB_BASE_RST = 20'h00000;
  localparam logic [31:0] DMB_SETUP_RST = 32'h00000000;
  localparam logic [31:0] DMB_XLAT_RST = 32'h00000000;
  localparam logic [31:0] DMB_DW_ZERO = 32'h00000000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] off;
    logic [3:0] be;
    logic [31:0] wdata;
  } dmb_cfg_req_s;

  typedef struct packed {
    logic ack;
    logic claim;
    logic [31:0] rdata;
  } dmb_cfg_rsp_s;

  typedef struct packed {
    logic req;
    logic [11:0] off;
    logic [31:0] wdata;
  } dmb_cs_wr_s;

  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } dmb_txn_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic xlat;
    logic [63:0] addr;
  } dmb_fwd_s;

  typedef struct packed {
    logic [DMB_BASE_W-1:0] base;
    logic [31:0] setup;
    logic [31:0] usetup;
    logic [31:0] xlat;
    dmb_cfg_rsp_s cfg;
    dmb_fwd_s fwd;
  } dmb_state_s;

endpackage
